/* core/audio_clock_monitor_and_source_select.sv */
`timescale 1ns/1ps
module audio_clock_monitor_and_source_select #(
  parameter int TIMEOUT_CYC = audio_clk_pkg::FRAME_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial audio port clocks from the far end
  input wire logic bit_clk_pin,
  input wire logic frame_sync_pin,
  // Clock tree controls
  output logic root_from_master_clk,
  output logic root_from_bit_clk,
  output logic pll_enable,
  output logic master_clk_uses_ratio,
  output logic [11:0] master_clk_ratio,
  output logic [15:0] master_clk_freq_khz,
  output logic [3:0] detected_frame_rate_code,
  output logic [3:0] detected_bitclk_frame_ratio_code,
  output logic irq
);
  import audio_clk_pkg::*;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // One byte per register in bits 7:0, at four times the index.
  //
  // Monitor status (0x15), read only, writes dropped:
  //   7:4 frame rate code, 0..8 valid, 15 no match or no clocks
  //   3:0 bit clocks per frame code, 0..12 valid, 15 invalid
  //   Codes 9..14 and 13..14 are never produced.
  //
  // Root clock source (0x16):
  //   7   slave root, 0 bit clock, 1 master clock
  //   6   master clock spec, 0 fixed table, 1 ratio
  //   5:3 master clock to frame sync ratio code
  //   2:0 reserved, always read as zero
  //
  // Mode control (0x17), local to this block:
  //   0 master mode, 1 manual clocking, 2 PLL off in auto
  //   6:4 fixed master clock frequency code
  //
  // Interrupt status (0x18), write one to clear:
  //   0 a detected code changed, 1 frame sync went quiet
  // Interrupt mask (0x19), same layout, one enables.
  //
  // Unmapped reads return zero; unmapped writes are dropped.
  // Limitation: a rate drifting across a window edge may
  // flip the codes each frame and raise an event each time.

  typedef struct packed {
    logic [7:0] mon_status;
    logic [7:0] root_src;
    logic [7:0] mode_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic root_mclk;
    logic root_bclk;
    logic pll_en;
    logic use_ratio;
    logic [11:0] mclk_ratio;
    logic [15:0] mclk_freq;
  } regs_t;

  regs_t r_q, r_d;
  monitor_if mon ();

  // ----------------------------------------------------------------
  // Serial clock measurement
  // ----------------------------------------------------------------
  serial_clock_meter #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_meter (
    .clk_sys(clk_sys),
    .srst(srst),
    .bit_clk_pin(bit_clk_pin),
    .frame_sync_pin(frame_sync_pin),
    .mon(mon)
  );

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  logic hit_status, hit_root, hit_mode, hit_irq_st, hit_irq_mk;
  logic wr_take, rd_take;
  logic [7:0] wbyte;
  logic [IRQ_W-1:0] irq_set;

  // Byte address is index times four; low two bits must be zero
  assign hit_status = (avs_address == {IDX_MON_STATUS[5:0], 2'b00});
  assign hit_root = (avs_address == {IDX_ROOT_SRC[5:0], 2'b00});
  assign hit_mode = (avs_address == {IDX_MODE_CTRL[5:0], 2'b00});
  assign hit_irq_st = (avs_address == {IDX_IRQ_STATUS[5:0], 2'b00});
  assign hit_irq_mk = (avs_address == {IDX_IRQ_MASK[5:0], 2'b00});
  assign wbyte = avs_writedata[7:0];

  // A request completes at the edge where waitrequest is seen low
  assign wr_take = avs_write & ~r_q.waitreq & avs_byteenable[0];
  assign rd_take = avs_read & r_q.waitreq;

  // Hardware events for the sticky status bits
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_STATUS_CHG] = mon.update;
    irq_set[IRQ_CLOCK_LOSS] = mon.lost;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic auto_cfg, slave, pll_off;
  logic [2:0] ratio_sel, freq_sel;

  always_comb begin
    r_d = r_q;
    auto_cfg = ~r_q.mode_ctrl[MODE_MANUAL_BIT];
    slave = ~r_q.mode_ctrl[MODE_MASTER_BIT];
    pll_off = r_q.mode_ctrl[MODE_PLL_OFF_BIT];
    ratio_sel = r_q.root_src[RATIO_LSB +: 3];
    freq_sel = r_q.mode_ctrl[FREQ_LSB +: 3];

    // Status mirror: only the meter changes it, writes are ignored
    r_d.mon_status = {mon.rate_code, mon.ratio_code};

    // One wait state: drop waitrequest for one cycle per request
    if (r_q.waitreq) begin
      if (avs_read || avs_write) begin
        r_d.waitreq = 1'b0;
      end
    end else begin
      r_d.waitreq = 1'b1;
    end

    // Read data are captured when waitrequest drops
    if (rd_take) begin
      if (hit_status) begin
        r_d.rdata = {24'h000000, r_q.mon_status};
      end else if (hit_root) begin
        r_d.rdata = {24'h000000, r_q.root_src & ROOT_SRC_WMASK};
      end else if (hit_mode) begin
        r_d.rdata = {24'h000000, r_q.mode_ctrl};
      end else if (hit_irq_st) begin
        r_d.rdata = {{(32 - IRQ_W){1'b0}}, r_q.irq_status};
      end else if (hit_irq_mk) begin
        r_d.rdata = {{(32 - IRQ_W){1'b0}}, r_q.irq_mask};
      end else begin
        r_d.rdata = 32'h00000000;
      end
    end

    // Writes; unmapped addresses and the status register ignore them
    if (wr_take) begin
      if (hit_root) begin
        r_d.root_src = wbyte & ROOT_SRC_WMASK;
      end else if (hit_mode) begin
        r_d.mode_ctrl = wbyte & MODE_CTRL_WMASK;
      end else if (hit_irq_mk) begin
        r_d.irq_mask = wbyte[IRQ_W-1:0];
      end
    end

    // Write one to clear; an event in the same cycle wins
    if (wr_take && hit_irq_st) begin
      r_d.irq_status = (r_q.irq_status & ~wbyte[IRQ_W-1:0]) | irq_set;
    end else begin
      r_d.irq_status = r_q.irq_status | irq_set;
    end
    r_d.irq = |(r_q.irq_status & r_q.irq_mask);

    // Root clock choice only applies to auto slave mode with the PLL off
    r_d.pll_en = ~(auto_cfg & pll_off);
    r_d.root_mclk = auto_cfg & slave & pll_off & r_q.root_src[ROOT_SEL_BIT];
    r_d.root_bclk = auto_cfg & slave & pll_off & ~r_q.root_src[ROOT_SEL_BIT];

    // Master clock specification for auto master mode and for a master clock root
    r_d.use_ratio = 1'b0;
    r_d.mclk_ratio = 12'h000;
    r_d.mclk_freq = 16'h0000;
    if (auto_cfg && !slave) begin
      if (r_q.root_src[SPEC_MODE_BIT]) begin
        r_d.use_ratio = 1'b1;
        r_d.mclk_ratio = MCLK_RATIO[ratio_sel];
      end else begin
        r_d.mclk_freq = MCLK_FREQ_KHZ[freq_sel];
      end
    end else if (auto_cfg && slave && pll_off && r_q.root_src[ROOT_SEL_BIT]) begin
      r_d.use_ratio = 1'b1;
      r_d.mclk_ratio = MCLK_RATIO[ratio_sel];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q <= '0;
      r_q.mon_status <= MON_STATUS_RST;
      r_q.root_src <= ROOT_SRC_RST;
      r_q.mode_ctrl <= MODE_CTRL_RST;
      r_q.waitreq <= 1'b1;
      r_q.pll_en <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign avs_readdata = r_q.rdata;
  assign avs_waitrequest = r_q.waitreq;
  assign root_from_master_clk = r_q.root_mclk;
  assign root_from_bit_clk = r_q.root_bclk;
  assign pll_enable = r_q.pll_en;
  assign master_clk_uses_ratio = r_q.use_ratio;
  assign master_clk_ratio = r_q.mclk_ratio;
  assign master_clk_freq_khz = r_q.mclk_freq;
  assign detected_frame_rate_code = r_q.mon_status[7:4];
  assign detected_bitclk_frame_ratio_code = r_q.mon_status[3:0];
  assign irq = r_q.irq;

endmodule // audio_clock_monitor_and_source_select

/* core/audio_clk_pkg.sv */
package audio_clk_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 250;
  // Silence on frame sync longer than this means the clocks stopped
  localparam int FRAME_TIMEOUT_US = 160;
  localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * CLK_SYS_MHZ;

  // ----------------------------------------------------------------
  // Measurement widths and code tables
  // ----------------------------------------------------------------
  localparam int PERIOD_W = 16;
  localparam int BITCNT_W = 12;
  localparam int RATE_CODES = 9;
  localparam int RATIO_CODES = 13;
  localparam logic [3:0] CODE_INVALID = 4'hF;

  // Frame period window per rate code, in system clocks, +-2 percent around both rates of the pair
  localparam logic [PERIOD_W-1:0] PERIOD_LO [RATE_CODES] = '{
    16'h77A1, 16'h3BD1, 16'h27E0, 16'h1DE8, 16'h13F0, 16'h09F8, 16'h04FC, 16'h027E, 16'h013F};
  localparam logic [PERIOD_W-1:0] PERIOD_HI [RATE_CODES] = '{
    16'h8786, 16'h43C3, 16'h2D2D, 16'h21E1, 16'h1696, 16'h0B4B, 16'h05A5, 16'h02D3, 16'h0169};

  // Bit clocks per frame for each ratio code
  localparam logic [BITCNT_W-1:0] BCLK_RATIO [RATIO_CODES] = '{
    12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060, 12'h080,
    12'h0C0, 12'h100, 12'h180, 12'h200, 12'h400, 12'h800};

  // Master clock to frame sync ratio per 3-bit code
  localparam logic [11:0] MCLK_RATIO [8] = '{
    12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900};

  // Fixed master clock frequency per 3-bit code, in kHz
  localparam logic [15:0] MCLK_FREQ_KHZ [8] = '{
    16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80, 16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MON_STATUS = 8'h15;
  localparam logic [7:0] IDX_ROOT_SRC = 8'h16;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h17;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h19;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MON_STATUS_RST = 8'hFF;
  localparam logic [7:0] ROOT_SRC_RST = 8'h10;
  localparam logic [7:0] MODE_CTRL_RST = 8'h20;
  localparam logic [7:0] ROOT_SRC_WMASK = 8'hF8;
  localparam logic [7:0] MODE_CTRL_WMASK = 8'h77;
  localparam int ROOT_SEL_BIT = 7;
  localparam int SPEC_MODE_BIT = 6;
  localparam int RATIO_LSB = 3;
  localparam int MODE_MASTER_BIT = 0;
  localparam int MODE_MANUAL_BIT = 1;
  localparam int MODE_PLL_OFF_BIT = 2;
  localparam int FREQ_LSB = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_STATUS_CHG = 0;
  localparam int IRQ_CLOCK_LOSS = 1;

endpackage

/* core/monitor_if.sv */
`timescale 1ns/1ps
interface monitor_if;
  logic [3:0] rate_code;
  logic [3:0] ratio_code;
  logic update;
  logic lost;
  modport meas (output rate_code, output ratio_code, output update, output lost);
  modport ctrl (input rate_code, input ratio_code, input update, input lost);
endinterface

/* core/serial_clock_meter.sv */
`timescale 1ns/1ps
module serial_clock_meter #(
  parameter int TIMEOUT_CYC = audio_clk_pkg::FRAME_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic bit_clk_pin,
  input wire logic frame_sync_pin,
  monitor_if.meas mon
);
  import audio_clk_pkg::*;

  typedef struct packed {
    logic [1:0] bclk_sync;
    logic [1:0] fs_sync;
    logic bclk_prev;
    logic fs_prev;
    logic seen;
    logic [PERIOD_W-1:0] period;
    logic [BITCNT_W-1:0] bits;
    logic [3:0] rate;
    logic [3:0] ratio;
    logic update;
    logic lost;
  } meter_t;

  meter_t s_q, s_d;
  logic [RATE_CODES-1:0] rate_hit;
  logic [RATIO_CODES-1:0] ratio_hit;
  logic [3:0] rate_new, ratio_new;
  logic bclk_edge, fs_edge;

  // ----------------------------------------------------------------
  // Code matching
  // ----------------------------------------------------------------
  for (genvar i = 0; i < RATE_CODES; i++) begin : g_rate
    assign rate_hit[i] = (s_q.period >= PERIOD_LO[i]) && (s_q.period <= PERIOD_HI[i]);
  end
  for (genvar j = 0; j < RATIO_CODES; j++) begin : g_ratio
    assign ratio_hit[j] = (s_q.bits == BCLK_RATIO[j]);
  end

  // Windows do not overlap, so the lowest hit is the only hit
  always_comb begin
    rate_new = CODE_INVALID;
    ratio_new = CODE_INVALID;
    for (int k = RATE_CODES - 1; k >= 0; k--) begin
      if (rate_hit[k]) begin
        rate_new = 4'(k);
      end
    end
    for (int k = RATIO_CODES - 1; k >= 0; k--) begin
      if (ratio_hit[k]) begin
        ratio_new = 4'(k);
      end
    end
  end

  assign bclk_edge = s_q.bclk_sync[1] & ~s_q.bclk_prev;
  assign fs_edge = s_q.fs_sync[1] & ~s_q.fs_prev;

  // ----------------------------------------------------------------
  // Frame-by-frame measurement
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.bclk_sync = {s_q.bclk_sync[0], bit_clk_pin};
    s_d.fs_sync = {s_q.fs_sync[0], frame_sync_pin};
    s_d.bclk_prev = s_q.bclk_sync[1];
    s_d.fs_prev = s_q.fs_sync[1];
    s_d.update = 1'b0;
    s_d.lost = 1'b0;
    // Counters saturate so a slow clock reads as a miss, not a wrap
    if (s_q.period != '1) begin
      s_d.period = s_q.period + PERIOD_W'(1);
    end
    if (bclk_edge && s_q.bits != '1) begin
      s_d.bits = s_q.bits + BITCNT_W'(1);
    end
    if (fs_edge) begin
      s_d.period = PERIOD_W'(1);
      s_d.bits = bclk_edge ? BITCNT_W'(1) : '0;
      s_d.seen = 1'b1;
      // First edge after silence only opens a measurement
      if (s_q.seen) begin
        s_d.rate = rate_new;
        s_d.ratio = ratio_new;
        s_d.update = (rate_new != s_q.rate) || (ratio_new != s_q.ratio);
      end
    end else if (s_q.seen && s_q.period >= PERIOD_W'(TIMEOUT_CYC)) begin
      s_d.seen = 1'b0;
      s_d.rate = CODE_INVALID;
      s_d.ratio = CODE_INVALID;
      s_d.update = (s_q.rate != CODE_INVALID) || (s_q.ratio != CODE_INVALID);
      s_d.lost = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
      s_q.rate <= CODE_INVALID;
      s_q.ratio <= CODE_INVALID;
    end else begin
      s_q <= s_d;
    end
  end

  assign mon.rate_code = s_q.rate;
  assign mon.ratio_code = s_q.ratio;
  assign mon.update = s_q.update;
  assign mon.lost = s_q.lost;

endmodule // serial_clock_meter

/* testbench/acm_props.sv */
`timescale 1ns/1ps
module acm_props #(
  parameter int TIMEOUT_CYC = 40000
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic frame_sync_pin,
  input wire logic root_from_master_clk,
  input wire logic root_from_bit_clk,
  input wire logic pll_enable,
  input wire logic master_clk_uses_ratio,
  input wire logic [11:0] master_clk_ratio,
  input wire logic [15:0] master_clk_freq_khz,
  input wire logic [3:0] detected_frame_rate_code,
  input wire logic [3:0] detected_bitclk_frame_ratio_code,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic fs_q;
  int idle_q;
  // Quiet time on frame sync; saturates so it never wraps
  always_ff @(posedge clk_sys) begin
    fs_q <= frame_sync_pin;
    if (srst || frame_sync_pin != fs_q) begin
      idle_q <= 0;
    end else if (idle_q < TIMEOUT_CYC + 100) begin
      idle_q <= idle_q + 1;
    end
  end
  // --------
  // Properties
  // --------
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_status_reset: assert property ($fell(srst) |-> {detected_frame_rate_code, detected_bitclk_frame_ratio_code} == 8'hFF)
    else $error("codes not invalid after reset");
  a_rate_legal: assert property (detected_frame_rate_code <= 4'h8 || detected_frame_rate_code == 4'hF)
    else $error("reserved rate code reported");
  a_ratio_legal: assert property (detected_bitclk_frame_ratio_code <= 4'hC || detected_bitclk_frame_ratio_code == 4'hF)
    else $error("reserved ratio code reported");
  a_root_single: assert property (!(root_from_master_clk && root_from_bit_clk))
    else $error("two root sources at once");
  a_root_pll_off: assert property (root_from_master_clk || root_from_bit_clk |-> !pll_enable)
    else $error("root select while pll runs");
  a_ratio_table: assert property (master_clk_uses_ratio || root_from_master_clk |-> master_clk_ratio inside
    {12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900}) else $error("bad master ratio");
  a_freq_split: assert property (master_clk_uses_ratio |-> master_clk_freq_khz == 16'h0000)
    else $error("fixed frequency beside ratio mode");
  a_freq_table: assert property (master_clk_freq_khz != 16'h0000 |-> master_clk_freq_khz inside
    {16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80, 16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000}) else $error("bad frequency");
  a_src_reserved: assert property (avs_read && !avs_waitrequest && avs_address == 8'h58 |-> avs_readdata[2:0] == 3'h0)
    else $error("reserved source bits read nonzero");
  // Margin covers the pin synchroniser and the status lag
  a_loss_invalid: assert property (idle_q == TIMEOUT_CYC + 16 |->
    {detected_frame_rate_code, detected_bitclk_frame_ratio_code} == 8'hFF) else $error("codes kept after clock loss");
  c_fast_rate: cover property (detected_frame_rate_code == 4'h8);
  c_mclk_root: cover property (root_from_master_clk);
  c_irq: cover property ($rose(irq));
endmodule // acm_props
bind audio_clock_monitor_and_source_select acm_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_acm_props (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_sync_pin(frame_sync_pin),
  .root_from_master_clk(root_from_master_clk), .root_from_bit_clk(root_from_bit_clk), .pll_enable(pll_enable),
  .master_clk_uses_ratio(master_clk_uses_ratio), .master_clk_ratio(master_clk_ratio),
  .master_clk_freq_khz(master_clk_freq_khz), .detected_frame_rate_code(detected_frame_rate_code),
  .detected_bitclk_frame_ratio_code(detected_bitclk_frame_ratio_code), .irq(irq));

/* testbench/serial_clock_source.sv */
`timescale 1ns/1ps
module serial_clock_source (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [7:0] half_bit,
  input wire logic [11:0] bits,
  output logic bit_clk_pin = 1'b0,
  output logic frame_sync_pin = 1'b0
);
  int hcnt = 0;
  int bcnt = 0;
  // Host bit clock from a half-period count; frame sync high for the first half frame.
  // A stopped host leaves both lines low, so the monitor must time out.
  // Counts compare with >= so a shorter setting taken mid-frame cannot strand them past the end
  always @(posedge clk_sys) begin
    if (!run) begin
      hcnt <= 0;
      bcnt <= 0;
      bit_clk_pin <= 1'b0;
      frame_sync_pin <= 1'b0;
    end else if (hcnt >= half_bit - 1) begin
      hcnt <= 0;
      bit_clk_pin <= ~bit_clk_pin;
      if (bit_clk_pin) begin
        bcnt <= (bcnt >= bits - 1) ? 0 : bcnt + 1;
        frame_sync_pin <= (bcnt >= bits - 1) || (bcnt + 1 < bits / 2);
      end
    end else begin
      hcnt <= hcnt + 1;
    end
  end
endmodule // serial_clock_source

/* testbench/audio_clock_monitor_and_source_select_tb.sv */
`timescale 1ns/1ps
module audio_clock_monitor_and_source_select_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, root_mclk, root_bclk, pll_enable, uses_ratio, irq, bclk, fsync;
  logic [11:0] ratio;
  logic [15:0] freq;
  logic [3:0] rate_code, ratio_code;
  logic run = 1'b0;
  logic [3:0] be = 4'hF;
  logic [7:0] half_bit = 8'h28;
  logic [11:0] bits = 12'h040;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [11:0] ratio_tab [8] = '{12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900};
  logic [15:0] freq_tab [8] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80, 16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};
  always #2 clk_sys = ~clk_sys;
  // Timeout kept above the slowest frame used here
  audio_clock_monitor_and_source_select #(.TIMEOUT_CYC(8000)) i_audio_clock_monitor_and_source_select (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bit_clk_pin(bclk), .frame_sync_pin(fsync),
    .root_from_master_clk(root_mclk), .root_from_bit_clk(root_bclk), .pll_enable(pll_enable),
    .master_clk_uses_ratio(uses_ratio), .master_clk_ratio(ratio), .master_clk_freq_khz(freq),
    .detected_frame_rate_code(rate_code), .detected_bitclk_frame_ratio_code(ratio_code), .irq(irq));
  serial_clock_source i_serial_clock_source (.clk_sys(clk_sys), .run(run), .half_bit(half_bit), .bits(bits),
    .bit_clk_pin(bclk), .frame_sync_pin(fsync));
  // --------
  // Tasks
  // --------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One bus cycle; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    if (i == 20) begin
      n_mismatch++;
      end_of_test();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Outputs follow a write two edges later: register, then output flop
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), {24'h0, exp}, rd);
  endtask
  // Codes may pass through other values while the host retunes
  task automatic wait_codes(input logic [3:0] r, input logic [3:0] q);
    int i;
    for (i = 0; i < 40000; i++) begin
      @(posedge clk_sys);
      if (rate_code === r && ratio_code === q) break;
    end
    if (i == 40000) begin
      n_mismatch++;
      end_of_test();
    end
    check("codes", {24'h0, r, q}, {24'h0, rate_code, ratio_code});
    rchk(8'h54, {r, q});
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    int k;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(8'h54, 8'hFF);
    rchk(8'h58, 8'h10);
    rchk(8'h80, 8'h00);
    bus(1'b1, 8'h54, 8'h00);
    rchk(8'h54, 8'hFF);
    bus(1'b1, 8'h58, 8'hF8);
    rchk(8'h58, 8'hF8);
    // A write with byte lane 0 disabled must leave the register alone
    be <= 4'h0;
    bus(1'b1, 8'h58, 8'h00);
    be <= 4'hF;
    rchk(8'h58, 8'hF8);
    bus(1'b1, 8'h5C, 8'h04);
    for (k = 0; k < 8; k++) begin
      bus(1'b1, 8'h58, {2'b10, k[2:0], 3'b000});
      check("mclk ratio", {20'h0, ratio_tab[k]}, {20'h0, ratio});
    end
    check("root", 32'h2, {30'h0, root_mclk, root_bclk});
    check("pll", 32'h0, {31'h0, pll_enable});
    bus(1'b1, 8'h58, 8'h10);
    rchk(8'h58, 8'h10);
    check("root", 32'h1, {30'h0, root_mclk, root_bclk});
    bus(1'b1, 8'h5C, 8'h06);
    rchk(8'h5C, 8'h06);
    check("pll", 32'h1, {31'h0, pll_enable});
    for (k = 0; k < 8; k++) begin
      bus(1'b1, 8'h5C, {1'b0, k[2:0], 4'h1});
      rchk(8'h5C, {1'b0, k[2:0], 4'h1});
      check("mclk freq", {16'h0, freq_tab[k]}, {16'h0, freq});
    end
    bus(1'b1, 8'h58, 8'h50);
    rchk(8'h58, 8'h50);
    check("ratio mode", 32'h1180, {19'h0, uses_ratio, ratio});
    check("mclk freq", 32'h0, {16'h0, freq});
    // Slave auto; host clocks measured with both events unmasked
    bus(1'b1, 8'h5C, 8'h00);
    bus(1'b1, 8'h64, 8'h03);
    run <= 1'b1;
    wait_codes(4'h4, 4'h4);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h60, 8'h03);
    rchk(8'h60, 8'h00);
    check("irq", 32'h0, {31'h0, irq});
    half_bit <= 8'h05;
    bits <= 12'h020;
    wait_codes(4'h8, 4'h2);
    half_bit <= 8'h32;
    bits <= 12'h040;
    wait_codes(4'hF, 4'h4);
    run <= 1'b0;
    wait_codes(4'hF, 4'hF);
    rchk(8'h60, 8'h03);
    check("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h64, 8'h00);
    rchk(8'h64, 8'h00);
    check("irq", 32'h0, {31'h0, irq});
    end_of_test();
  end
endmodule // audio_clock_monitor_and_source_select_tb
